/* File: src/ddr_bank_pkg.sv */
// What this block does
// - Precharge closes the row in one bank or all banks; they become idle.
// - Precharge-all flag high selects all banks; else bank select bits pick one.
// - Clock gate sampled low enters power-down; no access may be in progress. The block enters even with a read or write burst open.
// - Power-down is precharge type if all banks idle, else active type.
// - In power-down, buffers off except clock and clock gate; loop keeps running.
// - Clock gate high with deselect or no-op exits power-down; command next cycle.
// - Clock gate low on both samples keeps self refresh or power-down.
// - High-to-low clock gate enters self refresh or precharge or active power-down.
// - Commands decode from chip select, row, column and write strobes.
// - Idle bank accepts active, auto refresh and mode register set.
// - Row-active bank accepts read, write and precharge.
// - Read burst accepts new read, truncating precharge and burst terminate.
// - Write burst accepts read, new write and truncating precharge.
// - Burst terminate acts on the most recent read burst, any bank.
// - A bank counts idle only after the precharge period has elapsed.
package ddr_bank_pkg;
  localparam int NUM_BANKS       = 4;
  localparam int BANK_W          = 2;
  // Times in ns, converted to 200 MHz cycles (least times round up)
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int PRECHARGE_NS    = 15;
  localparam int ACTIVATE_NS     = 15;
  localparam int SR_EXIT_NS      = 75;
  localparam int PRECHARGE_CYC   = (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACTIVATE_CYC    = (ACTIVATE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SR_EXIT_CYC     = (SR_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOOP_LOCK_CYC   = 200;
  localparam int BURST_CYC       = 4;
  localparam int CNT_W           = 8;

  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVE, CMD_REFRESH, CMD_MODE_SET,
    CMD_READ, CMD_WRITE, CMD_PRECHARGE, CMD_BURST_STOP
  } cmd_t;

  typedef enum logic [2:0] {
    BANK_IDLE, BANK_ACTIVATING, BANK_ROW_ACTIVE, BANK_READING, BANK_WRITING, BANK_PRECHARGING
  } bank_state_t;

  typedef enum logic [1:0] {
    PWR_NORMAL, PWR_PRECHARGE_PD, PWR_ACTIVE_PD, PWR_SELF_REFRESH
  } power_state_t;

  typedef struct packed {
    logic              chip_select_n;
    logic              row_strobe_n;
    logic              column_strobe_n;
    logic              write_strobe_n;
    logic              precharge_all_flag;
    logic              bank_select_bit1;
    logic              bank_select_bit0;
  } cmd_pins_t;
endpackage

/* File: src/ddr_bank_ctl.sv */
`timescale 1ns/1ps
module ddr_bank_ctl (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire ddr_bank_pkg::cmd_pins_t      pins,
  input  wire logic                         clock_gate_input,
  output ddr_bank_pkg::bank_state_t         bank_state [ddr_bank_pkg::NUM_BANKS],
  output ddr_bank_pkg::power_state_t        power_state,
  output logic                              buffers_on,
  output logic                              all_idle,
  output logic                              illegal_cmd,
  output logic                              sr_exit_busy,
  output logic [ddr_bank_pkg::BANK_W-1:0]   last_read_bank,
  output logic                              burst_stopped
);
  import ddr_bank_pkg::*;

  // ****************************************
  // Command decode
  // ****************************************
  cmd_t                 cmd;
  logic                 cke_prev;
  logic [BANK_W-1:0]    bank_sel;
  logic                 idle_now;
  logic                 quiet_cmd;
  logic                 running;
  logic [NUM_BANKS-1:0] bank_idle;
  logic [NUM_BANKS-1:0] bank_reading;
  logic                 read_open;
  logic [CNT_W-1:0]     sr_cnt;

  always_comb begin
    if (pins.chip_select_n) begin
      cmd = CMD_DESELECT;
    end else begin
      case ({pins.row_strobe_n, pins.column_strobe_n, pins.write_strobe_n})
        3'h7:    cmd = CMD_NOP;
        3'h3:    cmd = CMD_ACTIVE;
        3'h1:    cmd = CMD_REFRESH;
        3'h0:    cmd = CMD_MODE_SET;
        3'h5:    cmd = CMD_READ;
        3'h4:    cmd = CMD_WRITE;
        3'h2:    cmd = CMD_PRECHARGE;
        default: cmd = CMD_BURST_STOP;
      endcase
    end
  end

  assign bank_sel  = {pins.bank_select_bit1, pins.bank_select_bit0};
  assign quiet_cmd = (cmd == CMD_DESELECT) || (cmd == CMD_NOP);
  assign idle_now  = &bank_idle;
  assign read_open = |bank_reading;
  // Commands are executed only with clock gate high on both samples
  assign running   = (power_state == PWR_NORMAL) && cke_prev && clock_gate_input
                     && !sr_exit_busy;

  // ****************************************
  // Clock gate and power state
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      cke_prev <= 1'b1;
    end else begin
      cke_prev <= clock_gate_input;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      power_state <= PWR_NORMAL;
      buffers_on  <= 1'b1;
    end else if (power_state == PWR_NORMAL) begin
      if (cke_prev && !clock_gate_input && !sr_exit_busy) begin
        if (idle_now && cmd == CMD_REFRESH) begin
          power_state <= PWR_SELF_REFRESH;
          buffers_on  <= 1'b0;
        end else if (quiet_cmd) begin
          power_state <= idle_now ? PWR_PRECHARGE_PD : PWR_ACTIVE_PD;
          buffers_on  <= 1'b0;
        end
      end
    end else if (clock_gate_input && quiet_cmd) begin
      power_state <= PWR_NORMAL;
      buffers_on  <= 1'b1;
    end
  end

  // Self refresh exit window: executable commands ignored meanwhile
  always_ff @(posedge clk) begin
    if (srst) begin
      sr_cnt       <= '0;
      sr_exit_busy <= 1'b0;
    end else if (power_state == PWR_SELF_REFRESH && clock_gate_input && quiet_cmd) begin
      sr_cnt       <= CNT_W'(SR_EXIT_CYC - 1);
      sr_exit_busy <= 1'b1;
    end else if (sr_cnt != '0) begin
      sr_cnt       <= sr_cnt - CNT_W'(1);
    end else begin
      sr_exit_busy <= 1'b0;
    end
  end

  // ****************************************
  // Per-bank state machines
  // ****************************************
  logic [NUM_BANKS-1:0] bank_bad;

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic [CNT_W-1:0] tmr;
    logic             hit;
    logic             pre_hit;
    assign hit     = bank_sel == BANK_W'(b);
    assign pre_hit = pins.precharge_all_flag || hit;
    assign bank_idle[b]    = bank_state[b] == BANK_IDLE;
    assign bank_reading[b] = bank_state[b] == BANK_READING;

    always_comb begin
      bank_bad[b] = 1'b0;
      // Burst stop and precharge-all do not belong to the addressed bank
      if (running && hit && cmd != CMD_BURST_STOP
          && !(cmd == CMD_PRECHARGE && pins.precharge_all_flag)) begin
        case (bank_state[b])
          BANK_IDLE:       bank_bad[b] = !(cmd inside {CMD_DESELECT, CMD_NOP, CMD_ACTIVE,
                                           CMD_REFRESH, CMD_MODE_SET});
          BANK_ROW_ACTIVE: bank_bad[b] = !(cmd inside {CMD_DESELECT, CMD_NOP, CMD_READ,
                                           CMD_WRITE, CMD_PRECHARGE});
          BANK_READING:    bank_bad[b] = !(cmd inside {CMD_DESELECT, CMD_NOP, CMD_READ,
                                           CMD_PRECHARGE, CMD_BURST_STOP});
          BANK_WRITING:    bank_bad[b] = !(cmd inside {CMD_DESELECT, CMD_NOP, CMD_READ,
                                           CMD_WRITE, CMD_PRECHARGE});
          default:         bank_bad[b] = !quiet_cmd;
        endcase
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        bank_state[b] <= BANK_IDLE;
        tmr           <= '0;
      end else begin
        if (tmr != '0) begin
          tmr <= tmr - CNT_W'(1);
        end
        case (bank_state[b])
          BANK_IDLE: begin
            if (running && hit && cmd == CMD_ACTIVE) begin
              bank_state[b] <= BANK_ACTIVATING;
              tmr           <= CNT_W'(ACTIVATE_CYC - 1);
            end
          end
          BANK_ACTIVATING: begin
            if (tmr == '0) begin
              bank_state[b] <= BANK_ROW_ACTIVE;
            end
          end
          BANK_PRECHARGING: begin
            if (tmr == '0) begin
              bank_state[b] <= BANK_IDLE;
            end
          end
          default: begin
            if (running && cmd == CMD_PRECHARGE && pre_hit) begin
              bank_state[b] <= BANK_PRECHARGING;
              tmr           <= CNT_W'(PRECHARGE_CYC - 1);
            end else if (running && hit && cmd == CMD_READ) begin
              bank_state[b] <= BANK_READING;
              tmr           <= CNT_W'(BURST_CYC - 1);
            end else if (running && hit && cmd == CMD_WRITE && !bank_reading[b]) begin
              bank_state[b] <= BANK_WRITING;
              tmr           <= CNT_W'(BURST_CYC - 1);
            end else if (running && cmd == CMD_BURST_STOP && bank_reading[b]
                         && last_read_bank == BANK_W'(b)) begin
              bank_state[b] <= BANK_ROW_ACTIVE;
            end else if (!running && cmd == CMD_READ && !hit) begin
              bank_state[b] <= bank_state[b];
            end else if (bank_state[b] != BANK_ROW_ACTIVE && tmr == '0) begin
              bank_state[b] <= BANK_ROW_ACTIVE;
            end
            if (running && !hit && (cmd == CMD_READ || cmd == CMD_WRITE)
                && bank_state[b] != BANK_ROW_ACTIVE) begin
              bank_state[b] <= BANK_ROW_ACTIVE; // Another bank's burst ends ours
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      last_read_bank <= '0;
      burst_stopped  <= 1'b0;
      illegal_cmd    <= 1'b0;
      all_idle       <= 1'b1;
    end else begin
      if (running && cmd == CMD_READ) begin
        last_read_bank <= bank_sel;
      end
      burst_stopped <= running && cmd == CMD_BURST_STOP && read_open;
      // Refresh and mode set need all banks idle, whichever bank is addressed
      illegal_cmd   <= (|bank_bad) || (running && !idle_now
                       && (cmd == CMD_REFRESH || cmd == CMD_MODE_SET))
                       || (running && cmd == CMD_BURST_STOP && !read_open);
      all_idle      <= idle_now;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_pd_entry;
    @(posedge clk) disable iff (srst)
      (power_state == PWR_NORMAL && cke_prev && !clock_gate_input && !sr_exit_busy
       && quiet_cmd) |=> (power_state inside {PWR_PRECHARGE_PD, PWR_ACTIVE_PD}) && !buffers_on;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

  property p_pd_kind;
    @(posedge clk) disable iff (srst)
      (power_state == PWR_NORMAL && cke_prev && !clock_gate_input && !sr_exit_busy
       && quiet_cmd)
        |=> power_state == ($past(idle_now) ? PWR_PRECHARGE_PD : PWR_ACTIVE_PD);
  endproperty
  a_pd_kind: assert property (p_pd_kind) else $error("wrong power-down kind");

  property p_pd_hold;
    @(posedge clk) disable iff (srst)
      (power_state != PWR_NORMAL && !clock_gate_input) |=> $stable(power_state);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("low clock gate left power state");

  property p_pd_exit;
    @(posedge clk) disable iff (srst)
      (power_state != PWR_NORMAL && clock_gate_input && quiet_cmd)
        |=> power_state == PWR_NORMAL && buffers_on;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down exit missed");

  property p_pre_all;
    @(posedge clk) disable iff (srst)
      (running && cmd == CMD_PRECHARGE && pins.precharge_all_flag
       && bank_state[3] == BANK_ROW_ACTIVE) |=> bank_state[3] == BANK_PRECHARGING;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all skipped a bank");

  property p_pre_time;
    @(posedge clk) disable iff (srst)
      $rose(bank_state[0] == BANK_PRECHARGING)
        |-> (bank_state[0] == BANK_PRECHARGING) [*3] ##1 bank_state[0] == BANK_IDLE;
  endproperty
  a_pre_time: assert property (p_pre_time) else $error("precharge period wrong");

  property p_idle_reject;
    @(posedge clk) disable iff (srst)
      (running && bank_sel == 2'h1 && bank_state[1] == BANK_IDLE && cmd == CMD_READ)
        |=> illegal_cmd && bank_state[1] == BANK_IDLE;
  endproperty
  a_idle_reject: assert property (p_idle_reject) else $error("read to idle bank accepted");

  property p_activate;
    @(posedge clk) disable iff (srst)
      (running && bank_sel == 2'h1 && bank_state[1] == BANK_IDLE && cmd == CMD_ACTIVE)
        |=> bank_state[1] == BANK_ACTIVATING ##[1:4] bank_state[1] == BANK_ROW_ACTIVE;
  endproperty
  a_activate: assert property (p_activate) else $error("row never opened");

  property p_sr_quiet;
    @(posedge clk) disable iff (srst)
      sr_exit_busy && cmd == CMD_ACTIVE |=> $stable(bank_idle);
  endproperty
  a_sr_quiet: assert property (p_sr_quiet) else $error("command run in exit period");

  c_self_refresh: cover property (@(posedge clk) disable iff (srst)
    power_state == PWR_SELF_REFRESH ##[1:20] power_state == PWR_NORMAL);
  c_active_pd: cover property (@(posedge clk) disable iff (srst)
    power_state == PWR_ACTIVE_PD);
  c_burst_stop: cover property (@(posedge clk) disable iff (srst) burst_stopped);
  c_write_pre: cover property (@(posedge clk) disable iff (srst)
    bank_state[0] == BANK_WRITING ##1 bank_state[0] == BANK_PRECHARGING);
endmodule

/* File: sim/ddr_ctl_model.sv */
`timescale 1ns/1ps
// ************************************************
// Controller side: drives commands and clock gate
// ************************************************
module ddr_ctl_model (
  input  wire logic          clk,
  output ddr_bank_pkg::cmd_pins_t pins,
  output logic               clock_gate_input
);
  import ddr_bank_pkg::*;

  logic [6:0] req;
  logic       req_tgl;
  logic       seen_tgl;
  logic       cke_req;

  initial begin
    req              = 7'h7F;
    req_tgl          = 1'b0;
    seen_tgl         = 1'b0;
    cke_req          = 1'b1;
    pins             = cmd_pins_t'(7'h7F);
    clock_gate_input = 1'b1;
  end

  // Deselected lines carry no meaning, so keep them moving
  // A toggle per send: back-to-back sends never drop and raise a flag at once
  always @(negedge clk) begin
    if (req_tgl != seen_tgl) begin
      pins <= cmd_pins_t'(req);
    end else begin
      pins <= cmd_pins_t'({1'b1, ~pins[5:0]});
    end
    seen_tgl         <= req_tgl;
    clock_gate_input <= cke_req;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Callers pace these by the bank timing
  task automatic send(input logic [3:0] code, input logic [1:0] bank, input logic all);
    req     = {code, all, bank};
    req_tgl = ~req_tgl;
    cyc(1);
  endtask

  // Self refresh preferred over long power-down
  task automatic set_cke(input logic level);
    cke_req = level;
  endtask
endmodule

/* File: sim/ddr_bank_ctl_test.sv */
`timescale 1ns/1ps
module ddr_bank_ctl_test;
  import ddr_bank_pkg::*;

  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_MRS = 4'h0;
  localparam logic [3:0] C_RD  = 4'h5;
  localparam logic [3:0] C_WR  = 4'h4;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_BST = 4'h6;

  logic              clk;
  logic              srst;
  cmd_pins_t         pins;
  logic              clock_gate_input;
  bank_state_t       bank_state [NUM_BANKS];
  power_state_t      power_state;
  logic              buffers_on;
  logic              all_idle;
  logic              illegal_cmd;
  logic              sr_exit_busy;
  logic [BANK_W-1:0] last_read_bank;
  logic              burst_stopped;
  int                bad_count = 0;
  int                checks_done = 0;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ddr_ctl_model ctl_u (.clk(clk), .pins(pins), .clock_gate_input(clock_gate_input));

  ddr_bank_ctl dut_u (
    .clk(clk), .srst(srst), .pins(pins), .clock_gate_input(clock_gate_input),
    .bank_state(bank_state), .power_state(power_state), .buffers_on(buffers_on),
    .all_idle(all_idle), .illegal_cmd(illegal_cmd), .sr_exit_busy(sr_exit_busy),
    .last_read_bank(last_read_bank), .burst_stopped(burst_stopped)
  );

  // ************************************************
  // Checking and closing
  // ************************************************
  task automatic chk(input bit ok, input string what);
    checks_done++;
    if (!ok) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s", $time, what);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_reset;
    for (int b = 0; b < NUM_BANKS; b++)
      chk(bank_state[b] === BANK_IDLE, "bank not idle after reset");
    chk(power_state === PWR_NORMAL && buffers_on === 1'b1, "power after reset");
    chk(all_idle === 1'b1 && illegal_cmd === 1'b0 && sr_exit_busy === 1'b0, "reset flags");
    $display("test reset done");
  endtask

  task automatic t_precharge;
    for (int b = 0; b < NUM_BANKS; b++)
      ctl_u.send(C_ACT, 2'(b), 1'b0);
    chk(bank_state[3] === BANK_ACTIVATING, "activate not seen");
    ctl_u.cyc(ACTIVATE_CYC);
    ctl_u.send(C_PRE, 2'h2, 1'b0);
    chk(bank_state[2] === BANK_PRECHARGING, "single precharge");
    chk(bank_state[1] === BANK_ROW_ACTIVE && bank_state[3] === BANK_ROW_ACTIVE, "wrong bank");
    ctl_u.cyc(PRECHARGE_CYC - 1);
    chk(bank_state[2] === BANK_PRECHARGING, "idle before period");
    ctl_u.cyc(1);
    chk(bank_state[2] === BANK_IDLE, "not idle after period");
    ctl_u.send(C_ACT, 2'h2, 1'b0);
    ctl_u.cyc(ACTIVATE_CYC);
    ctl_u.send(C_PRE, 2'h2, 1'b1);
    for (int b = 0; b < NUM_BANKS; b++)
      chk(bank_state[b] === BANK_PRECHARGING, "precharge all");
    ctl_u.cyc(PRECHARGE_CYC + 1);
    chk(all_idle === 1'b1 && bank_state[0] === BANK_IDLE, "all idle after precharge");
    $display("test precharge done");
  endtask

  task automatic t_bursts;
    ctl_u.send(C_ACT, 2'h0, 1'b0);
    ctl_u.send(C_ACT, 2'h3, 1'b0);
    ctl_u.cyc(ACTIVATE_CYC);
    ctl_u.send(C_RD, 2'h0, 1'b0);
    chk(bank_state[0] === BANK_READING && last_read_bank === 2'h0, "read start");
    ctl_u.send(C_RD, 2'h0, 1'b0);
    chk(bank_state[0] === BANK_READING && illegal_cmd === 1'b0, "read restart");
    ctl_u.send(C_WR, 2'h0, 1'b0);
    chk(illegal_cmd === 1'b1 && bank_state[0] === BANK_READING, "write in read");
    ctl_u.send(C_BST, 2'h3, 1'b0);
    chk(burst_stopped === 1'b1 && bank_state[0] === BANK_ROW_ACTIVE, "stop");
    chk(bank_state[3] === BANK_ROW_ACTIVE && illegal_cmd === 1'b0, "stop side effect");
    ctl_u.send(C_WR, 2'h3, 1'b0);
    chk(bank_state[3] === BANK_WRITING, "write start");
    ctl_u.send(C_RD, 2'h3, 1'b0);
    chk(bank_state[3] === BANK_READING && last_read_bank === 2'h3, "write to read");
    ctl_u.send(C_PRE, 2'h3, 1'b0);
    chk(bank_state[3] === BANK_PRECHARGING, "read truncated");
    ctl_u.send(C_WR, 2'h0, 1'b0);
    ctl_u.send(C_WR, 2'h0, 1'b0);
    chk(bank_state[0] === BANK_WRITING && illegal_cmd === 1'b0, "write restart");
    ctl_u.send(C_PRE, 2'h0, 1'b0);
    chk(bank_state[0] === BANK_PRECHARGING, "write truncated");
    ctl_u.cyc(PRECHARGE_CYC + 1);
    $display("test bursts done");
  endtask

  task automatic t_illegal;
    ctl_u.send(C_BST, 2'h2, 1'b0);
    chk(illegal_cmd === 1'b1 && burst_stopped === 1'b0, "stop with no read");
    ctl_u.send(C_RD, 2'h1, 1'b0);
    chk(illegal_cmd === 1'b1 && bank_state[1] === BANK_IDLE, "read on idle");
    ctl_u.send(C_ACT, 2'h1, 1'b0);
    ctl_u.cyc(ACTIVATE_CYC);
    ctl_u.send(C_REF, 2'h0, 1'b0);
    chk(illegal_cmd === 1'b1, "refresh with open row");
    ctl_u.send(C_MRS, 2'h0, 1'b0);
    chk(illegal_cmd === 1'b1 && bank_state[1] === BANK_ROW_ACTIVE, "mode set open row");
    ctl_u.send(C_PRE, 2'h1, 1'b0);
    ctl_u.cyc(PRECHARGE_CYC + 1);
    ctl_u.send(C_MRS, 2'h0, 1'b0);
    chk(illegal_cmd === 1'b0 && bank_state[0] === BANK_IDLE, "mode set idle");
    ctl_u.send(C_REF, 2'h0, 1'b0);
    chk(illegal_cmd === 1'b0, "refresh idle");
    ctl_u.cyc(2);
    $display("test illegal done");
  endtask

  task automatic t_power_down;
    ctl_u.set_cke(1'b0);
    ctl_u.cyc(1);
    chk(power_state === PWR_PRECHARGE_PD && buffers_on === 1'b0, "precharge pd");
    ctl_u.send(C_ACT, 2'h1, 1'b0);
    ctl_u.cyc(3);
    chk(power_state === PWR_PRECHARGE_PD && bank_state[1] === BANK_IDLE, "pd held");
    ctl_u.set_cke(1'b1);
    ctl_u.cyc(1);
    chk(power_state === PWR_NORMAL && buffers_on === 1'b1, "pd exit");
    ctl_u.send(C_ACT, 2'h1, 1'b0);
    chk(bank_state[1] === BANK_ACTIVATING, "command after exit");
    ctl_u.cyc(ACTIVATE_CYC);
    ctl_u.set_cke(1'b0);
    ctl_u.cyc(5);
    chk(power_state === PWR_ACTIVE_PD && bank_state[1] === BANK_ROW_ACTIVE, "active pd");
    ctl_u.set_cke(1'b1);
    ctl_u.cyc(1);
    chk(power_state === PWR_NORMAL, "active pd exit");
    ctl_u.send(C_PRE, 2'h0, 1'b1);
    chk(illegal_cmd === 1'b0 && bank_state[1] === BANK_PRECHARGING, "pre all, idle bank");
    ctl_u.cyc(PRECHARGE_CYC + 1);
    $display("test power down done");
  endtask

  task automatic t_self_refresh;
    ctl_u.set_cke(1'b0);
    ctl_u.send(C_REF, 2'h0, 1'b0);
    chk(power_state === PWR_SELF_REFRESH && illegal_cmd === 1'b0, "sr entry");
    ctl_u.cyc(5);
    chk(power_state === PWR_SELF_REFRESH && buffers_on === 1'b0, "sr held");
    ctl_u.set_cke(1'b1);
    ctl_u.cyc(1);
    chk(power_state === PWR_NORMAL && sr_exit_busy === 1'b1, "sr exit");
    ctl_u.send(C_ACT, 2'h0, 1'b0);
    chk(bank_state[0] === BANK_IDLE && illegal_cmd === 1'b0, "ignored in exit");
    ctl_u.cyc(SR_EXIT_CYC - 2);
    chk(sr_exit_busy === 1'b1, "exit period short");
    ctl_u.cyc(1);
    chk(sr_exit_busy === 1'b0, "exit period long");
    ctl_u.cyc(LOOP_LOCK_CYC);
    ctl_u.send(C_ACT, 2'h0, 1'b0);
    ctl_u.cyc(ACTIVATE_CYC);
    ctl_u.send(C_RD, 2'h0, 1'b0);
    chk(bank_state[0] === BANK_READING, "read after lock");
    $display("test self refresh done");
  endtask

  // ************************************************
  // Sequence and watchdog
  // ************************************************
  initial begin
    srst = 1'b1;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    ctl_u.cyc(1);
    t_reset;
    t_precharge;
    t_bursts;
    t_illegal;
    t_power_down;
    t_self_refresh;
    final_report;
  end

  // Run needs about 320 cycles; allow over fifteen times that
  initial begin
    #25000;
    bad_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    final_report;
  end
endmodule
